// ### src/ssf_defs.svh
// constants for the status unit parser: layout, codes, register map
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH
`define SSF_HDR_LEN 32'h0000000C
`define SSF_CRC_LEN 32'h00000004
`define SSF_B_FLAGS 32'h00000002
`define SSF_B_STATUS 32'h00000003
`define SSF_B_SLEN_LO 32'h00000004
`define SSF_B_SLEN_HI 32'h00000007
`define SSF_B_FLEN_LO 32'h00000008
`define SSF_B_FLEN_HI 32'h0000000B
`define SSF_SV_BIT 1
`define SSF_FV_BIT 0
`define SSF_FAIL_LEN_REQ 32'h00000004
`define SSF_FAIL_CODE_B 32'h00000003
`define SSF_SENSE_MAX 32'h000000FC
`define SSF_FC_NONE 8'h00
`define SSF_FC_CMD_BAD 8'h02
`define SSF_FC_TMF_UNSUP 8'h04
`define SSF_FC_TMF_FAIL 8'h05
`define SSF_STATUS_CHECK 8'h02
`define SSF_CRC_POLY 32'h04C11DB7
`define SSF_CRC_INIT 32'hFFFFFFFF
`define SSF_REG_CTRL 8'h00
`define SSF_REG_STAT 8'h04
`define SSF_REG_RESULT 8'h08
`define SSF_REG_SLEN 8'h0C
`define SSF_REG_FLEN 8'h10
`define SSF_REG_SIDX 8'h14
`define SSF_REG_SDATA 8'h18
`define SSF_REG_CRCRX 8'h1C
`define SSF_REG_COUNT 8'h20
`define SSF_CTRL_EN 0
`define SSF_CTRL_CLR 1
`define SSF_CTRL_ATN 2
`define SSF_ST_DONE 0
`define SSF_ST_BUSY 1
`define SSF_ST_FLAG0 2
`define SSF_ST_SV 8
`define SSF_ST_FV 9
`define SSF_ST_ATN 10
`define SSF_RESP_OKAY 2'h0
`define SSF_RESP_SLVERR 2'h2
`endif

// ### src/ssf_pkg.sv
// types and failure-code decoding for the status unit parser
package ssf_pkg;
`include "ssf_defs.svh"
	typedef enum logic [2:0] {ST_HDR, ST_FAIL, ST_SENSE, ST_CRC, ST_DONE} ssf_state_t;
	typedef enum logic [2:0] {
		FCL_NONE, FCL_CMD_BAD, FCL_TMF_UNSUP, FCL_TMF_FAIL, FCL_RESERVED
	} ssf_fclass_t;

	function automatic ssf_fclass_t ssf_fail_class(input logic [7:0] code);
		ssf_fclass_t c;
		c = FCL_RESERVED;
		if (code == `SSF_FC_NONE)
			c = FCL_NONE;
		else if (code == `SSF_FC_CMD_BAD)
			c = FCL_CMD_BAD;
		else if (code == `SSF_FC_TMF_UNSUP)
			c = FCL_TMF_UNSUP;
		else if (code == `SSF_FC_TMF_FAIL)
			c = FCL_TMF_FAIL;
		return c;
	endfunction : ssf_fail_class
endpackage : ssf_pkg

// ### src/ssf_crc32.sv
// bytewise 32-bit crc, msb first, no reflection
`timescale 1ns/100ps
module ssf_crc32 (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] data,
	output logic [31:0] crc
);
`include "ssf_defs.svh"
	logic [31:0] crc_reg;
	logic [31:0] crc_next;

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			if (r[31] ^ d[i])
				r = {r[30:0], 1'b0} ^ `SSF_CRC_POLY;
			else
				r = {r[30:0], 1'b0};
		end
		return r;
	endfunction : crc_step

	assign crc_next = clr ? `SSF_CRC_INIT : (en ? crc_step(crc_reg, data) : crc_reg);
	assign crc = crc_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			crc_reg <= `SSF_CRC_INIT;
		else
			crc_reg <= crc_next;
	end
endmodule : ssf_crc32

// ### src/ssf_axil.sv
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/100ps
module ssf_axil (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
`include "ssf_defs.svh"
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, rd_pend_reg;
	logic have_aw_reg, have_w_reg;
	logic [7:0] awaddr_reg, araddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	wire aw_hs = awvalid & awready_reg;
	wire w_hs = wvalid & wready_reg;
	wire ar_hs = arvalid & arready_reg;
	wire fire = have_aw_reg & have_w_reg & ~bvalid_reg;
	wire b_done = bvalid_reg & bready;
	wire r_done = rvalid_reg & rready;

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign wr_en = fire;
	assign wr_addr = awaddr_reg;
	assign wr_data = wdata_reg;
	assign wr_strb = wstrb_reg;
	assign rd_addr = araddr_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			arready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			have_aw_reg <= 1'b0;
			have_w_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			araddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			rdata_reg <= 32'h00000000;
			bresp_reg <= `SSF_RESP_OKAY;
			rresp_reg <= `SSF_RESP_OKAY;
		end
		else
		begin
			awready_reg <= b_done | (awready_reg & ~aw_hs);
			wready_reg <= b_done | (wready_reg & ~w_hs);
			have_aw_reg <= aw_hs | (have_aw_reg & ~fire);
			have_w_reg <= w_hs | (have_w_reg & ~fire);
			if (aw_hs)
				awaddr_reg <= awaddr;
			if (w_hs)
			begin
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
			bvalid_reg <= fire | (bvalid_reg & ~bready);
			if (fire)
				bresp_reg <= wr_ok ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
			arready_reg <= r_done | (arready_reg & ~ar_hs);
			rd_pend_reg <= ar_hs;
			if (ar_hs)
				araddr_reg <= araddr;
			rvalid_reg <= rd_pend_reg | (rvalid_reg & ~rready);
			if (rd_pend_reg)
			begin
				rdata_reg <= rd_data;
				rresp_reg <= rd_ok ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
			end
		end
	end
endmodule : ssf_axil

// ### src/ssf_status_rx.sv
// initiator-side receiver and checker for the packetized status unit
`timescale 1ns/100ps
// Behaviour
// - byte 3 status, byte 2 bit 0 flag
// - bytes 4-7 sense length, big-endian
// - bytes 8-11 failure length; record, sense, crc
// - sense flag decides sense bytes present
// - no sense flag: sense length zero
// - no failure flag: failure length zero
// - failure record four bytes, code last
// - codes 00h, 02h, 04h, 05h defined; others reserved
// - codes 04h unsupported, 05h failed
// - trailing check is the iucrc
module ssf_status_rx
	import ssf_pkg::*;
#(
	parameter int SENSE_DEPTH = 252
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] iu_data,
	input wire logic iu_valid,
	output logic iu_ready,
	output logic atn
);
`include "ssf_defs.svh"
	localparam logic [31:0] DEPTH32 = 32'(SENSE_DEPTH);
	logic wr_en, wr_ok, rd_ok;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data, crc_val;
	logic [3:0] wr_strb;
	ssf_state_t state_reg, state_next;
	logic [31:0] idx_reg, idx_next;
	logic [31:0] slen_reg, flen_reg, slen_eff_reg, flen_eff_reg, crc_rx_reg;
	logic [7:0] status_reg, code_reg, sidx_reg;
	logic sv_reg, fv_reg, en_reg, atn_en_reg, ready_reg, atn_reg, done_reg;
	logic [5:0] flags_reg;
	logic [15:0] good_cnt_reg, bad_cnt_reg;
	logic [7:0] sense_mem [SENSE_DEPTH];

	ssf_axil u_axil (
		.clk(clk),
		.resetn(resetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// register writes
	wire wr_ctrl = wr_en & wr_strb[0] & (wr_addr == `SSF_REG_CTRL);
	wire wr_sidx = wr_en & wr_strb[0] & (wr_addr == `SSF_REG_SIDX);
	wire clr = wr_ctrl & wr_data[`SSF_CTRL_CLR];
	wire en_next = wr_ctrl ? wr_data[`SSF_CTRL_EN] : en_reg;
	wire atn_en_next = wr_ctrl ? wr_data[`SSF_CTRL_ATN] : atn_en_reg;

	// byte stream section decoding
	wire take = iu_valid & ready_reg;
	wire in_hdr = state_reg == ST_HDR;
	wire in_fail = state_reg == ST_FAIL;
	wire in_sense = state_reg == ST_SENSE;
	wire in_crc = state_reg == ST_CRC;
	wire hdr_last = in_hdr & (idx_reg == `SSF_HDR_LEN - 32'h1);
	wire fail_last = in_fail & (idx_reg == flen_eff_reg - 32'h1);
	wire sense_last = in_sense & (idx_reg == slen_eff_reg - 32'h1);
	wire crc_last = in_crc & (idx_reg == `SSF_CRC_LEN - 32'h1);
	wire sec_end = take & (hdr_last | fail_last | sense_last | crc_last);
	wire flags_byte = in_hdr & (idx_reg == `SSF_B_FLAGS);
	wire status_byte = in_hdr & (idx_reg == `SSF_B_STATUS);
	wire slen_byte = in_hdr & (idx_reg >= `SSF_B_SLEN_LO) & (idx_reg <= `SSF_B_SLEN_HI);
	wire flen_byte = in_hdr & (idx_reg >= `SSF_B_FLEN_LO) & (idx_reg <= `SSF_B_FLEN_HI);
	wire code_byte = in_fail & (idx_reg == `SSF_FAIL_CODE_B);

	// lengths complete on the last header byte; a clear flag forces zero
	wire [31:0] flen_full = {flen_reg[23:0], iu_data};
	wire [31:0] slen_eff_w = sv_reg ? slen_reg : 32'h0;
	wire [31:0] flen_eff_w = fv_reg ? flen_full : 32'h0;

	// format checks on what the target sent
	wire slen_bad = (slen_reg == 32'h0) | slen_reg[0] | (slen_reg > `SSF_SENSE_MAX);
	wire e_slen = take & hdr_last & sv_reg & slen_bad;
	wire e_flen = take & hdr_last & fv_reg & (flen_full != `SSF_FAIL_LEN_REQ);
	wire e_code = take & code_byte & (ssf_fail_class(iu_data) == FCL_RESERVED);
	wire e_chk = take & hdr_last & (status_reg == `SSF_STATUS_CHECK) & ~sv_reg;
	wire [31:0] crc_rx_full = {crc_rx_reg[23:0], iu_data};
	wire e_crc = take & crc_last & (crc_rx_full != crc_val);
	// reserved bytes are only reported; parsing goes on regardless
	wire rsv_hdr = in_hdr & (idx_reg < `SSF_B_FLAGS) & (iu_data != 8'h00);
	wire rsv_flg = flags_byte & (iu_data[7:2] != 6'h00);
	wire rsv_rec = in_fail & (idx_reg < `SSF_FAIL_CODE_B) & (iu_data != 8'h00);
	wire e_rsv = take & (rsv_hdr | rsv_flg | rsv_rec);
	wire [5:0] events = {e_rsv, e_chk, e_code, e_flen, e_slen, e_crc};
	wire any_err = |events;
	wire unit_end = take & crc_last;
	wire unit_bad = any_err | (|flags_reg);

	// set wins over clear on every sticky flag
	wire [5:0] flags_next = events | (flags_reg & ~{6{clr}});
	wire done_next = unit_end | (done_reg & ~clr);
	// attention tells the target the unit was not taken cleanly
	wire atn_next = (atn_en_reg & any_err) | (atn_reg & ~clr);
	wire ready_next = en_next & (state_next != ST_DONE);

	// crc covers every byte before the trailing check field
	wire crc_en = take & ~in_crc & (state_reg != ST_DONE);

	ssf_crc32 u_crc (
		.clk(clk),
		.resetn(resetn),
		.clr(clr),
		.en(crc_en),
		.data(iu_data),
		.crc(crc_val)
	);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_HDR:
				if (take & hdr_last)
					state_next = (flen_eff_w != 32'h0) ? ST_FAIL :
						((slen_eff_w != 32'h0) ? ST_SENSE : ST_CRC);
			ST_FAIL:
				if (take & fail_last)
					state_next = (slen_eff_reg != 32'h0) ? ST_SENSE : ST_CRC;
			ST_SENSE:
				if (take & sense_last)
					state_next = ST_CRC;
			ST_CRC:
				if (take & crc_last)
					state_next = ST_DONE;
			ST_DONE:
				state_next = ST_DONE;
			default:
				state_next = ST_HDR;
		endcase
		if (clr)
			state_next = ST_HDR;
	end

	assign idx_next = (clr | sec_end) ? 32'h0 : (take ? idx_reg + 32'h1 : idx_reg);

	// register reads
	wire [31:0] ctrl_rd = {29'h0, atn_en_reg, 1'b0, en_reg};
	wire [31:0] stat_rd = {21'h0, atn_reg, fv_reg, sv_reg, flags_reg,
		(state_reg != ST_HDR) & (state_reg != ST_DONE), done_reg};
	wire [2:0] fclass = 3'(ssf_fail_class(code_reg));
	wire [31:0] result_rd = {13'h0, fclass, code_reg, status_reg};
	wire [7:0] sense_rd = (32'(sidx_reg) < DEPTH32) ? sense_mem[sidx_reg] : 8'h00;
	wire is_ctrl = rd_addr == `SSF_REG_CTRL;
	wire is_stat = rd_addr == `SSF_REG_STAT;
	wire is_res = rd_addr == `SSF_REG_RESULT;
	wire is_slen = rd_addr == `SSF_REG_SLEN;
	wire is_flen = rd_addr == `SSF_REG_FLEN;
	wire is_sidx = rd_addr == `SSF_REG_SIDX;
	wire is_sdat = rd_addr == `SSF_REG_SDATA;
	wire is_crcr = rd_addr == `SSF_REG_CRCRX;
	wire is_cnt = rd_addr == `SSF_REG_COUNT;
	assign rd_ok = is_ctrl | is_stat | is_res | is_slen | is_flen | is_sidx | is_sdat |
		is_crcr | is_cnt;
	assign rd_data = is_ctrl ? ctrl_rd :
		is_stat ? stat_rd :
		is_res ? result_rd :
		is_slen ? slen_eff_reg :
		is_flen ? flen_eff_reg :
		is_sidx ? {24'h0, sidx_reg} :
		is_sdat ? {24'h0, sense_rd} :
		is_crcr ? crc_rx_reg :
		is_cnt ? {bad_cnt_reg, good_cnt_reg} : 32'h0;
	// writes to read-only words are accepted and ignored
	assign wr_ok = (wr_addr[1:0] == 2'h0) & (wr_addr <= `SSF_REG_COUNT);

	assign iu_ready = ready_reg;
	assign atn = atn_reg;

	// sense store, clipped to the buffer depth
	genvar g;
	generate
		for (g = 0; g < SENSE_DEPTH; g++)
		begin : g_sense
			wire hit = take & in_sense & (idx_reg == 32'(g));
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					sense_mem[g] <= 8'h00;
				else if (hit)
					sense_mem[g] <= iu_data;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= ST_HDR;
			idx_reg <= 32'h0;
			en_reg <= 1'b0;
			atn_en_reg <= 1'b0;
			ready_reg <= 1'b0;
			atn_reg <= 1'b0;
			done_reg <= 1'b0;
			flags_reg <= 6'h00;
			sidx_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			en_reg <= en_next;
			atn_en_reg <= atn_en_next;
			ready_reg <= ready_next;
			atn_reg <= atn_next;
			done_reg <= done_next;
			flags_reg <= flags_next;
			if (wr_sidx)
				sidx_reg <= wr_data[7:0];
		end
	end

	// header fields and parsed results
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sv_reg <= 1'b0;
			fv_reg <= 1'b0;
			status_reg <= 8'h00;
			code_reg <= 8'h00;
			slen_reg <= 32'h0;
			flen_reg <= 32'h0;
			slen_eff_reg <= 32'h0;
			flen_eff_reg <= 32'h0;
			crc_rx_reg <= 32'h0;
		end
		else if (take)
		begin
			if (flags_byte)
			begin
				sv_reg <= iu_data[`SSF_SV_BIT];
				fv_reg <= iu_data[`SSF_FV_BIT];
			end
			if (status_byte)
				status_reg <= iu_data;
			if (slen_byte)
				slen_reg <= {slen_reg[23:0], iu_data};
			if (flen_byte)
				flen_reg <= flen_full;
			if (hdr_last)
			begin
				slen_eff_reg <= slen_eff_w;
				flen_eff_reg <= flen_eff_w;
				code_reg <= 8'h00;
			end
			if (code_byte)
				code_reg <= iu_data;
			if (in_crc)
				crc_rx_reg <= crc_rx_full;
		end
	end

	// unit tallies, wrapping
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			good_cnt_reg <= 16'h0000;
			bad_cnt_reg <= 16'h0000;
		end
		else if (unit_end)
		begin
			if (unit_bad)
				bad_cnt_reg <= bad_cnt_reg + 16'h0001;
			else
				good_cnt_reg <= good_cnt_reg + 16'h0001;
		end
	end
endmodule : ssf_status_rx

// ### testbench/ssf_status_chk_sva.sv
// port checker for the status unit receiver
`timescale 1ns/100ps
module ssf_status_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic iu_valid,
	input wire logic iu_ready,
	input wire logic atn
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// bytes taken since the stream opened; a unit can never be shorter than 16
	logic [8:0] nb_reg;
	logic [8:0] nb_next;
	assign nb_next = iu_ready ? nb_reg + 9'(iu_valid) : 9'h000;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			nb_reg <= 9'h000;
		else
			nb_reg <= nb_next;
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer off time");
	property p_busy_w;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_busy_w: assert property (p_busy_w) else $error("write taken while busy");
	property p_busy_r;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_busy_r: assert property (p_busy_r) else $error("read taken while busy");
	property p_atn_clr;
		$fell(atn) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_atn_clr: assert property (p_atn_clr) else $error("atn fell without clear");
	property p_end_taken;
		$fell(iu_ready) |-> $past(iu_valid) && $past(iu_ready);
	endproperty
	a_end_taken: assert property (p_end_taken) else $error("stream closed idle");
	property p_unit_len;
		$fell(iu_ready) |-> nb_reg >= 9'h010;
	endproperty
	a_unit_len: assert property (p_unit_len) else $error("unit too short");
endmodule : ssf_status_chk

// ### testbench/ssf_tgt_model.sv
// target model: builds status units and streams them byte by byte
`timescale 1ns/100ps
`include "ssf_defs.svh"
module ssf_tgt_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic iu_ready,
	output logic [7:0] iu_data,
	output logic iu_valid
);
	logic [7:0] q[$];
	logic [31:0] crc_sent;
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		c = c ^ {b, 24'h000000};
		for (int i = 0; i < 8; i++)
			c = c[31] ? ((c << 1) ^ `SSF_CRC_POLY) : (c << 1);
		return c;
	endfunction : crc_step
	// illegal lengths or codes only when a scenario asks for them
	task automatic send(input logic [7:0] st, input logic sv, input logic fv,
		input logic [31:0] sl, input logic [31:0] fl, input logic [7:0] fc,
		input logic [7:0] rv, input logic bc);
		logic [7:0] u[$];
		logic [31:0] c;
		u = '{rv, 8'h00, {6'h00, sv, fv}, st};
		for (int i = 3; i >= 0; i--)
			u.push_back(sl[8 * i +: 8]);
		for (int i = 3; i >= 0; i--)
			u.push_back(fl[8 * i +: 8]);
		for (int i = 0; i < (fv ? fl : 0); i++)
			u.push_back(i == 3 ? fc : 8'h00);
		for (int i = 0; i < (sv ? sl : 0); i++)
			u.push_back(8'(i * 3 + 8'h5A));
		c = `SSF_CRC_INIT;
		foreach (u[i])
			c = crc_step(c, u[i]);
		crc_sent = c;
		c[0] = c[0] ^ bc;
		for (int i = 3; i >= 0; i--)
			u.push_back(c[8 * i +: 8]);
		q = {q, u};
	endtask : send
	// a byte stays until taken; idle data toggles so stale values cannot pass
	always @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			iu_valid <= 1'h0;
			iu_data <= 8'h00;
		end
		else if (!iu_valid || iu_ready)
		begin
			if (iu_valid)
				void'(q.pop_front());
			if (q.size() > 0 && !(slow && $urandom_range(3) == 0))
			begin
				iu_valid <= 1'h1;
				iu_data <= q[0];
			end
			else
			begin
				iu_valid <= 1'h0;
				iu_data <= ~iu_data;
			end
		end
endmodule : ssf_tgt_model

// ### testbench/tb_top.sv
// bench: target model feeds status units, axi4-lite master checks every result
`timescale 1ns/100ps
`include "ssf_defs.svh"
module tb_top;
	logic clk = 1'h0, resetn = 1'h0, slow = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, iu_data;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic iu_valid, iu_ready, atn;
	int bad_count = 0, comparisons = 0, good_n = 0, bad_n = 0;
	ssf_status_rx #(.SENSE_DEPTH(252)) u_dut (.*);
	ssf_tgt_model u_tgt (.*);
	always #50 clk = ~clk;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		check($sformatf("reg %h", a), d, e);
		check("rresp", 32'(r), 32'(er));
	endtask : rdchk
	function automatic logic [2:0] cls(input logic [7:0] c);
		return c == 8'h00 ? 3'h0 : c == 8'h02 ? 3'h1 : c == 8'h04 ? 3'h2 : c == 8'h05 ? 3'h3 : 3'h4;
	endfunction : cls
	task automatic unit(input logic [7:0] st, input logic sv, input logic fv,
		input logic [31:0] sl, input logic [31:0] fl, input logic [7:0] fc,
		input logic [7:0] rv, input logic bc, input logic [31:0] ctl);
		logic [31:0] d, es, esl;
		logic [1:0] r;
		int k;
		axi_wr(`SSF_REG_CTRL, ctl, r);
		u_tgt.send(st, sv, fv, sl, fl, fc, rv, bc);
		k = 0;
		do
		begin
			axi_rd(`SSF_REG_STAT, d, r);
			k++;
		end while (d[0] !== 1'h1 && k < 400);
		// atn lands on the same edge as the error flags; the status is read once more
		axi_rd(`SSF_REG_STAT, d, r);
		esl = sv ? sl : 32'h0;
		es = 32'h1;
		es[2] = bc;
		es[3] = sv && (sl == 0 || sl[0] || sl > 252);
		es[4] = fv && fl != 4;
		es[5] = fv && fl >= 4 && !(fc inside {8'h00, 8'h02, 8'h04, 8'h05});
		es[6] = st == 8'h02 && !sv;
		es[7] = rv != 8'h00;
		es[8] = sv;
		es[9] = fv;
		es[10] = ctl[2] && es[7:2] != 0;
		if (es[7:2] != 0)
			bad_n++;
		else
			good_n++;
		check("stat", d, es);
		check("atn", 32'(atn), 32'(es[10]));
		axi_rd(`SSF_REG_RESULT, d, r);
		check("status", 32'(d[7:0]), 32'(st));
		if (fv && fl == 4)
			check("fcode", 32'(d[18:8]), 32'({cls(fc), fc}));
		rdchk(`SSF_REG_SLEN, esl, `SSF_RESP_OKAY);
		rdchk(`SSF_REG_FLEN, fv ? fl : 32'h0, `SSF_RESP_OKAY);
		rdchk(`SSF_REG_CRCRX, u_tgt.crc_sent ^ 32'(bc), `SSF_RESP_OKAY);
		rdchk(`SSF_REG_COUNT, {16'(bad_n), 16'(good_n)}, `SSF_RESP_OKAY);
		if (esl != 0)
		begin
			k = $urandom_range((esl > 252 ? 252 : esl) - 1);
			axi_wr(`SSF_REG_SIDX, k, r);
			rdchk(`SSF_REG_SDATA, 32'(8'(k * 3 + 8'h5A)), `SSF_RESP_OKAY);
		end
	endtask : unit
	task automatic tally_and_finish;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#6000000;
		bad_count++;
		tally_and_finish;
	end
	initial
	begin
		logic [1:0] r;
		logic [7:0] fcs [8];
		logic [31:0] s;
		fcs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hFF};
		void'($urandom(861));
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		rdchk(`SSF_REG_STAT, 32'h0, `SSF_RESP_OKAY);
		rdchk(`SSF_REG_CTRL, 32'h0, `SSF_RESP_OKAY);
		rdchk(8'h24, 32'h0, `SSF_RESP_SLVERR);
		axi_wr(8'h02, 32'h1, r);
		check("bresp", 32'(r), 32'(`SSF_RESP_SLVERR));
		axi_wr(`SSF_REG_STAT, 32'hFFFFFFFF, r);
		check("bresp", 32'(r), 32'(`SSF_RESP_OKAY));
		unit(8'h00, 1'h0, 1'h0, 0, 0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h02, 1'h1, 1'h0, 252, 0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h02, 1'h1, 1'h1, 2, 4, 8'h02, 8'h00, 1'h0, 7);
		unit(8'h00, 1'h0, 1'h0, 32'h12345678, 32'h9ABCDEF0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h00, 1'h1, 1'h0, 0, 0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h00, 1'h1, 1'h0, 5, 0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h00, 1'h1, 1'h0, 254, 0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h00, 1'h0, 1'h1, 0, 8, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h02, 1'h0, 1'h0, 0, 0, 8'h00, 8'h00, 1'h0, 7);
		unit(8'h00, 1'h0, 1'h0, 0, 0, 8'h00, 8'h80, 1'h0, 7);
		unit(8'h00, 1'h0, 1'h0, 0, 0, 8'h00, 8'h00, 1'h1, 3);
		unit(8'h00, 1'h0, 1'h0, 0, 0, 8'h00, 8'h00, 1'h1, 7);
		foreach (fcs[i])
		begin
			slow <= i[0];
			unit(8'h00, 1'h0, 1'h1, 0, 4, fcs[i], 8'h00, 1'h0, 7);
		end
		slow <= 1'h1;
		repeat (3)
			unit(8'($urandom), 1'($urandom), 1'($urandom), 2 * $urandom_range(126, 1), 4,
				8'($urandom), 8'h00, 1'h0, 7);
		rdchk(`SSF_REG_CTRL, 32'h5, `SSF_RESP_OKAY);
		axi_wr(`SSF_REG_SIDX, 32'hFC, r);
		rdchk(`SSF_REG_SDATA, 32'h0, `SSF_RESP_OKAY);
		// clear with the stream disabled: flags and attention drop, no byte is taken
		axi_wr(`SSF_REG_CTRL, 32'h2, r);
		check("atn", 32'(atn), 32'h0);
		check("ready", 32'(iu_ready), 32'h0);
		rdchk(`SSF_REG_CTRL, 32'h0, `SSF_RESP_OKAY);
		axi_rd(`SSF_REG_STAT, s, r);
		check("stat", 32'(s[7:0]), 32'h0);
		tally_and_finish;
	end
endmodule : tb_top
bind ssf_status_rx ssf_status_chk u_chk (.*);
